//--- deiu_consts.svh
// Offsets, field positions, reset values and thresholds of the event interrupt unit
`ifndef DEIU_CONSTS_SVH
`define DEIU_CONSTS_SVH

// ---------
// Register offsets
// ---------
`define DEIU_OFS_IRQ_ENABLE_A  7'h03
`define DEIU_OFS_IRQ_ENABLE_B  7'h04
`define DEIU_OFS_IRQ_FLAGS_A   7'h05
`define DEIU_OFS_IRQ_FLAGS_B   7'h06
`define DEIU_OFS_IRQ_ROUTE_A   7'h07
`define DEIU_OFS_IRQ_ROUTE_B   7'h08
`define DEIU_OFS_FRAME_PIN_CFG 7'h09

// ---------
// Implemented bits and reset values
// ---------
`define DEIU_MASK_A            8'h7f
`define DEIU_MASK_B            8'hf7
`define DEIU_MASK_FRAME        8'h33
`define DEIU_RST_REG           8'h00

// ---------
// Bit positions, group a
// ---------
`define DEIU_BIT_SYNC_LOST     6
`define DEIU_BIT_SYNC_LOCKED   5
`define DEIU_BIT_SYNC_DONE     4
`define DEIU_BIT_PLL_UNLOCK    3
`define DEIU_BIT_PLL_LOCK      2
`define DEIU_BIT_OVER_THRESH   1
`define DEIU_BIT_OUTPUT_MUTE   0

// ---------
// Bit positions, group b
// ---------
`define DEIU_BIT_PARITY_FAIL   7
`define DEIU_BIT_SAMPLE_CHECK  6
`define DEIU_BIT_DLL_WARN      5
`define DEIU_BIT_DLL_LOCK      4
`define DEIU_BIT_FIFO_UNDER    2
`define DEIU_BIT_FIFO_OVER     1
`define DEIU_BIT_FIFO_LEVEL    0

// ---------
// Frame pin config fields
// ---------
`define DEIU_BIT_PARITY_USE    5
`define DEIU_BIT_FRAME_USE     4
`define DEIU_FN_NONE           2'h0
`define DEIU_FN_PARITY         2'h1
`define DEIU_FN_FRAME          2'h2

// ---------
// FIFO level alert thresholds
// ---------
`define DEIU_FIFO_LOW          3'h1
`define DEIU_FIFO_HIGH         3'h6

`endif

//--- deiu_pkg.sv
// Types shared by the event interrupt unit
package deiu_pkg;

    typedef logic [7:0] deiu_byte_t;
    typedef logic [6:0] deiu_addr_t;
    typedef logic [1:0] deiu_pin_fn_t;

    typedef enum logic [1:0] {
        DEIU_ST_INSTR,
        DEIU_ST_DATA,
        DEIU_ST_DONE
    } deiu_spi_state_e;

endpackage

//--- deiu_flag_bank.sv
// Sticky event flags, write one to clear, set wins over clear
`timescale 1ns/10ps
module deiu_flag_bank #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // Events and software clear
    input  wire logic [W-1:0] set_vec,
    input  wire logic         clr_en,
    input  wire logic [W-1:0] clr_vec,
    // Flags
    output logic      [W-1:0] flags_ff
);

    logic [W-1:0] nxt_flags;

    always_comb begin
        nxt_flags = flags_ff;
        if (clr_en) begin
            nxt_flags = nxt_flags & ~clr_vec;
        end
        nxt_flags = nxt_flags | set_vec;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flags_ff <= '0;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

endmodule // deiu_flag_bank

//--- deiu_spi_slave.sv
// Three-wire serial control port: instruction byte then one data byte
`timescale 1ns/10ps
module deiu_spi_slave
    import deiu_pkg::*;
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    // Serial pins
    input  wire logic             sclk,
    input  wire logic             cs_b,
    input  wire logic             sdio_in,
    output logic                  sdio_out,
    output logic                  sdio_oe,
    // Register access
    output deiu_pkg::deiu_addr_t  addr_ff,
    output logic                  wr_ff,
    output deiu_pkg::deiu_byte_t  wdata_ff,
    input  wire deiu_pkg::deiu_byte_t rd_data
);

    logic [1:0]      sclk_sync_ff;
    logic [1:0]      cs_sync_ff;
    logic [1:0]      sd_sync_ff;
    logic            sclk_prev_ff;
    logic            rise;
    logic            fall;
    deiu_spi_state_e state_ff;
    logic [2:0]      cnt_ff;
    logic [6:0]      shift_ff;
    logic            rd_ff;
    deiu_byte_t      tx_ff;

    // ---------
    // Pin synchronisers
    // ---------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_sync_ff <= 2'h0;
            cs_sync_ff   <= 2'h3;
            sd_sync_ff   <= 2'h0;
            sclk_prev_ff <= 1'b0;
        end else begin
            sclk_sync_ff <= {sclk_sync_ff[0], sclk};
            cs_sync_ff   <= {cs_sync_ff[0], cs_b};
            sd_sync_ff   <= {sd_sync_ff[0], sdio_in};
            sclk_prev_ff <= sclk_sync_ff[1];
        end
    end

    assign rise = sclk_sync_ff[1] & ~sclk_prev_ff;
    assign fall = ~sclk_sync_ff[1] & sclk_prev_ff;

    // ---------
    // Frame sequencer, MSB first
    // ---------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= DEIU_ST_INSTR;
            cnt_ff   <= 3'h0;
            shift_ff <= 7'h00;
            rd_ff    <= 1'b0;
            addr_ff  <= 7'h00;
            wr_ff    <= 1'b0;
            wdata_ff <= 8'h00;
        end else begin
            wr_ff <= 1'b0;
            if (cs_sync_ff[1]) begin
                state_ff <= DEIU_ST_INSTR;
                cnt_ff   <= 3'h0;
            end else if (rise) begin
                shift_ff <= {shift_ff[5:0], sd_sync_ff[1]};
                cnt_ff   <= cnt_ff + 3'h1;
                case (state_ff)
                    DEIU_ST_INSTR: begin
                        if (cnt_ff == 3'h7) begin
                            rd_ff    <= shift_ff[6];
                            addr_ff  <= {shift_ff[5:0], sd_sync_ff[1]};
                            state_ff <= DEIU_ST_DATA;
                        end
                    end
                    DEIU_ST_DATA: begin
                        if (cnt_ff == 3'h7) begin
                            wr_ff    <= ~rd_ff;
                            wdata_ff <= {shift_ff, sd_sync_ff[1]};
                            state_ff <= DEIU_ST_DONE;
                        end
                    end
                    default: begin
                        state_ff <= DEIU_ST_DONE;
                    end
                endcase
            end
        end
    end

    // ---------
    // Read data driven on falling edges
    // ---------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_ff   <= 8'h00;
            sdio_oe <= 1'b0;
        end else if (cs_sync_ff[1]) begin
            sdio_oe <= 1'b0;
        end else if (fall) begin
            if (state_ff == DEIU_ST_DATA && rd_ff) begin
                sdio_oe <= 1'b1;
                tx_ff   <= (cnt_ff == 3'h0) ? rd_data : {tx_ff[6:0], 1'b0};
            end else begin
                sdio_oe <= 1'b0;
            end
        end
    end

    assign sdio_out = tx_ff[7];

endmodule // deiu_spi_slave

//--- deiu_top.sv
// Event interrupt unit: flags, enables, routing, frame pin config, serial port
//
// Functional notes
// - Group a enables at bits 6..0, all reset to zero.
// - Group b enables at bits 7..4 and 2..0, bit 3 unused, reset zero.
// - Sync loss sets flag a bit 6.
// - Sync lock sets flag a bit 5.
// - Sync procedure finished sets flag a bit 4.
// - PLL losing lock sets flag a bit 3.
// - PLL achieving lock sets flag a bit 2.
// - Input power above threshold sets flag a bit 1.
// - Output forced to midscale sets flag a bit 0.
// - Parity check failure sets flag b bit 7.
// - Sample check mismatch sets flag b bit 6.
// - DLL warning sets flag b bit 5.
// - DLL reaching lock sets flag b bit 4.
// - Read pointer catching write pointer sets flag b bit 2.
// - Write pointer catching read pointer sets flag b bit 1.
// - FIFO occupancy at most 1 or at least 6 sets flag b bit 0.
// - Route bit 1 steers a source to pin b, 0 to pin a.
// - Route registers share bit positions with enable and flag registers.
`timescale 1ns/10ps
`include "deiu_consts.svh"
module deiu_top (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    // Serial control port
    input  wire logic                 spi_sclk,
    input  wire logic                 spi_cs_b,
    input  wire logic                 spi_sdio_in,
    output logic                      spi_sdio_out,
    output logic                      spi_sdio_oe,
    // Sync, clock and power status
    input  wire logic                 ev_sync_lost,
    input  wire logic                 ev_sync_locked,
    input  wire logic                 ev_sync_done,
    input  wire logic                 ev_pll_unlock,
    input  wire logic                 ev_pll_lock,
    input  wire logic                 ev_over_threshold,
    input  wire logic                 ev_output_muted,
    // Data interface status
    input  wire logic                 ev_parity_fail,
    input  wire logic                 ev_sample_check_fail,
    input  wire logic                 ev_dll_warning,
    input  wire logic                 ev_dll_lock,
    // FIFO pointers
    input  wire logic [2:0]           fifo_wr_ptr,
    input  wire logic [2:0]           fifo_rd_ptr,
    input  wire logic                 fifo_wr_adv,
    input  wire logic                 fifo_rd_adv,
    // Interrupt pins
    output logic                      irq_out_a,
    output logic                      irq_out_b,
    // Shared pin configuration
    output logic                      parity_pin_in_use,
    output logic                      frame_pin_in_use,
    output deiu_pkg::deiu_pin_fn_t    shared_pin_function
);
    import deiu_pkg::*;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic ptr_catch(input logic [2:0] mover,
                                       input logic [2:0] target);
        ptr_catch = ((mover + 3'h1) == target);
    endfunction

    function automatic logic hit(input deiu_addr_t a,
                                 input deiu_addr_t ofs);
        hit = (a == ofs);
    endfunction

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    deiu_addr_t   reg_addr;
    logic         reg_wr;
    deiu_byte_t   reg_wdata;
    deiu_byte_t   rd_data;
    logic         sdio_out_int;
    logic         sdio_oe_int;

    deiu_byte_t   enable_a_ff;
    deiu_byte_t   enable_b_ff;
    deiu_byte_t   route_a_ff;
    deiu_byte_t   route_b_ff;
    deiu_byte_t   frame_cfg_ff;

    logic [6:0]   stat_a;
    logic [6:0]   stat_a_prev_ff;
    logic [6:0]   set_a;
    logic [7:0]   stat_b;
    logic [7:0]   stat_b_prev_ff;
    logic [7:0]   set_b;
    logic [6:0]   flags_a;
    logic [7:0]   flags_b;

    logic [2:0]   fifo_fill;
    logic         fifo_level_alert;
    logic         fifo_under;
    logic         fifo_over;

    logic         pend_a;
    logic         pend_b;

    // ----------------------------------------
    // Serial port
    // ----------------------------------------
    deiu_spi_slave u_spi (
        .clk      (clk),
        .rst_b    (rst_b),
        .sclk     (spi_sclk),
        .cs_b     (spi_cs_b),
        .sdio_in  (spi_sdio_in),
        .sdio_out (sdio_out_int),
        .sdio_oe  (sdio_oe_int),
        .addr_ff  (reg_addr),
        .wr_ff    (reg_wr),
        .wdata_ff (reg_wdata),
        .rd_data  (rd_data)
    );

    assign spi_sdio_out = sdio_out_int;
    assign spi_sdio_oe  = sdio_oe_int;

    // ----------------------------------------
    // Enable registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            enable_a_ff <= `DEIU_RST_REG;
        end else if (reg_wr && hit(reg_addr, `DEIU_OFS_IRQ_ENABLE_A)) begin
            enable_a_ff <= reg_wdata & `DEIU_MASK_A;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            enable_b_ff <= `DEIU_RST_REG;
        end else if (reg_wr && hit(reg_addr, `DEIU_OFS_IRQ_ENABLE_B)) begin
            enable_b_ff <= reg_wdata & `DEIU_MASK_B;
        end
    end

    // ----------------------------------------
    // Routing registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            route_a_ff <= `DEIU_RST_REG;
        end else if (reg_wr && hit(reg_addr, `DEIU_OFS_IRQ_ROUTE_A)) begin
            route_a_ff <= reg_wdata & `DEIU_MASK_A;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            route_b_ff <= `DEIU_RST_REG;
        end else if (reg_wr && hit(reg_addr, `DEIU_OFS_IRQ_ROUTE_B)) begin
            route_b_ff <= reg_wdata & `DEIU_MASK_B;
        end
    end

    // ----------------------------------------
    // Frame pin configuration
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            frame_cfg_ff <= `DEIU_RST_REG;
        end else if (reg_wr && hit(reg_addr, `DEIU_OFS_FRAME_PIN_CFG)) begin
            frame_cfg_ff <= reg_wdata & `DEIU_MASK_FRAME;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            parity_pin_in_use   <= 1'b0;
            frame_pin_in_use    <= 1'b0;
            shared_pin_function <= `DEIU_FN_NONE;
        end else begin
            parity_pin_in_use   <= frame_cfg_ff[`DEIU_BIT_PARITY_USE];
            frame_pin_in_use    <= frame_cfg_ff[`DEIU_BIT_FRAME_USE];
            shared_pin_function <= frame_cfg_ff[1:0];
        end
    end

    // ----------------------------------------
    // FIFO pointer events
    // ----------------------------------------
    assign fifo_fill        = fifo_wr_ptr - fifo_rd_ptr;
    assign fifo_level_alert = (fifo_fill <= `DEIU_FIFO_LOW) ||
                              (fifo_fill >= `DEIU_FIFO_HIGH);
    assign fifo_under       = fifo_rd_adv && !fifo_wr_adv &&
                              ptr_catch(fifo_rd_ptr, fifo_wr_ptr);
    assign fifo_over        = fifo_wr_adv && !fifo_rd_adv &&
                              ptr_catch(fifo_wr_ptr, fifo_rd_ptr);

    // ----------------------------------------
    // Status vectors in flag bit order
    // ----------------------------------------
    always_comb begin
        stat_a = 7'h00;
        stat_a[`DEIU_BIT_SYNC_LOST]   = ev_sync_lost;
        stat_a[`DEIU_BIT_SYNC_LOCKED] = ev_sync_locked;
        stat_a[`DEIU_BIT_SYNC_DONE]   = ev_sync_done;
        stat_a[`DEIU_BIT_PLL_UNLOCK]  = ev_pll_unlock;
        stat_a[`DEIU_BIT_PLL_LOCK]    = ev_pll_lock;
        stat_a[`DEIU_BIT_OVER_THRESH] = ev_over_threshold;
        stat_a[`DEIU_BIT_OUTPUT_MUTE] = ev_output_muted;
    end

    always_comb begin
        stat_b = 8'h00;
        stat_b[`DEIU_BIT_PARITY_FAIL]  = ev_parity_fail;
        stat_b[`DEIU_BIT_SAMPLE_CHECK] = ev_sample_check_fail;
        stat_b[`DEIU_BIT_DLL_WARN]     = ev_dll_warning;
        stat_b[`DEIU_BIT_DLL_LOCK]     = ev_dll_lock;
        stat_b[`DEIU_BIT_FIFO_LEVEL]   = fifo_level_alert;
    end

    // ----------------------------------------
    // Rising edge of each status condition, pointer catch events set directly
    // ----------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stat_a_prev_ff <= 7'h00;
            stat_b_prev_ff <= 8'h00;
        end else begin
            stat_a_prev_ff <= stat_a;
            stat_b_prev_ff <= stat_b;
        end
    end

    always_comb begin
        set_a = stat_a & ~stat_a_prev_ff;
        set_b = stat_b & ~stat_b_prev_ff;
        set_b[`DEIU_BIT_FIFO_UNDER] = fifo_under;
        set_b[`DEIU_BIT_FIFO_OVER]  = fifo_over;
        set_b[3] = 1'b0;
    end

    // ----------------------------------------
    // Sticky flags
    // ----------------------------------------
    deiu_flag_bank #(
        .W (7)
    ) u_flags_a (
        .clk      (clk),
        .rst_b    (rst_b),
        .set_vec  (set_a),
        .clr_en   (reg_wr && hit(reg_addr, `DEIU_OFS_IRQ_FLAGS_A)),
        .clr_vec  (reg_wdata[6:0]),
        .flags_ff (flags_a)
    );

    deiu_flag_bank #(
        .W (8)
    ) u_flags_b (
        .clk      (clk),
        .rst_b    (rst_b),
        .set_vec  (set_b),
        .clr_en   (reg_wr && hit(reg_addr, `DEIU_OFS_IRQ_FLAGS_B)),
        .clr_vec  (reg_wdata),
        .flags_ff (flags_b)
    );

    // ----------------------------------------
    // Interrupt pins
    // ----------------------------------------
    always_comb begin
        pend_a = |({1'b0, flags_a} & enable_a_ff & ~route_a_ff) |
                 |(flags_b & enable_b_ff & ~route_b_ff);
        pend_b = |({1'b0, flags_a} & enable_a_ff & route_a_ff) |
                 |(flags_b & enable_b_ff & route_b_ff);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_out_a <= 1'b0;
            irq_out_b <= 1'b0;
        end else begin
            irq_out_a <= pend_a;
            irq_out_b <= pend_b;
        end
    end

    // ----------------------------------------
    // Readback, unmapped reads as zero
    // ----------------------------------------
    always_comb begin
        case (reg_addr)
            `DEIU_OFS_IRQ_ENABLE_A:  rd_data = enable_a_ff;
            `DEIU_OFS_IRQ_ENABLE_B:  rd_data = enable_b_ff;
            `DEIU_OFS_IRQ_FLAGS_A:   rd_data = {1'b0, flags_a};
            `DEIU_OFS_IRQ_FLAGS_B:   rd_data = flags_b;
            `DEIU_OFS_IRQ_ROUTE_A:   rd_data = route_a_ff;
            `DEIU_OFS_IRQ_ROUTE_B:   rd_data = route_b_ff;
            `DEIU_OFS_FRAME_PIN_CFG: rd_data = frame_cfg_ff;
            default:                 rd_data = 8'h00;
        endcase
    end

endmodule // deiu_top

//--- deiu_host_model.sv
// Host side of the three-wire serial control port
`timescale 1ns/10ps
module deiu_host_model (
    // Clock
    input  wire logic clk,
    // Serial pins
    output logic      sclk,
    output logic      cs_b,
    output logic      sdio,
    input  wire logic sdio_out
);
    int unsigned half = 5;

    initial begin
        sclk = 1'b0;
        cs_b = 1'b1;
        sdio = 1'b0;
    end

    // ---------
    // One frame: instruction byte, data byte
    // ---------
    task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
        logic [15:0] w;
        w = {rd, a, d};
        q = 8'h00;
        @(posedge clk);
        cs_b <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            @(posedge clk);
            // Released line toggles during read data
            if (rd && i < 8) sdio <= ~sdio;
            else sdio <= w[i];
            repeat (half) @(posedge clk);
            q = {q[6:0], sdio_out};
            sclk <= 1'b1;
            repeat (half) @(posedge clk);
            sclk <= 1'b0;
        end
        repeat (half) @(posedge clk);
        cs_b <= 1'b1;
        sdio <= ~sdio;
        repeat (half) @(posedge clk);
    endtask
endmodule // deiu_host_model

//--- deiu_top_monitor.sv
// Pin-level checker of the event interrupt unit
`timescale 1ns/10ps
module deiu_top_monitor (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst_b,
    // Serial port
    input wire logic       spi_sclk,
    input wire logic       spi_cs_b,
    input wire logic       spi_sdio_out,
    input wire logic       spi_sdio_oe,
    // Events
    input wire logic       ev_sync_lost,
    input wire logic       ev_sync_locked,
    input wire logic       ev_sync_done,
    input wire logic       ev_pll_unlock,
    input wire logic       ev_pll_lock,
    input wire logic       ev_over_threshold,
    input wire logic       ev_output_muted,
    input wire logic       ev_parity_fail,
    input wire logic       ev_sample_check_fail,
    input wire logic       ev_dll_warning,
    input wire logic       ev_dll_lock,
    input wire logic [2:0] fifo_wr_ptr,
    input wire logic [2:0] fifo_rd_ptr,
    input wire logic       fifo_wr_adv,
    input wire logic       fifo_rd_adv,
    // Outputs
    input wire logic       irq_out_a,
    input wire logic       irq_out_b,
    input wire logic       parity_pin_in_use,
    input wire logic       frame_pin_in_use,
    input wire logic [1:0] shared_pin_function
);
    logic [10:0] ev_q;
    logic [5:0]  ptr_q;
    logic        sclk_q;
    logic [3:0]  cause_age;
    logic [3:0]  spi_age;
    logic [3:0]  fall_age;
    wire  [10:0] ev_now = {ev_sync_lost, ev_sync_locked, ev_sync_done, ev_pll_unlock, ev_pll_lock,
        ev_over_threshold, ev_output_muted, ev_parity_fail, ev_sample_check_fail, ev_dll_warning, ev_dll_lock};
    wire         cause = (|(ev_now & ~ev_q)) || fifo_wr_adv || fifo_rd_adv || !spi_cs_b
        || ptr_q != {fifo_wr_ptr, fifo_rd_ptr};

    // Cycles since a possible cause, saturating
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ev_q      <= 11'h000;
            ptr_q     <= 6'h00;
            sclk_q    <= 1'b0;
            cause_age <= 4'hf;
            spi_age   <= 4'hf;
            fall_age  <= 4'hf;
        end else begin
            ev_q      <= ev_now;
            ptr_q     <= {fifo_wr_ptr, fifo_rd_ptr};
            sclk_q    <= spi_sclk;
            cause_age <= cause ? 4'h0 : cause_age + {3'h0, cause_age != 4'hf};
            spi_age   <= !spi_cs_b ? 4'h0 : spi_age + {3'h0, spi_age != 4'hf};
            fall_age  <= (sclk_q && !spi_sclk) ? 4'h0 : fall_age + {3'h0, fall_age != 4'hf};
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_rst_quiet;
        $rose(rst_b) |-> !irq_out_a && !irq_out_b && !spi_sdio_oe;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("Pins active after reset");
    property p_rise_a;
        $rose(irq_out_a) |-> cause_age < 4'h8;
    endproperty
    a_rise_a: assert property (p_rise_a) else $error("Pin a rose without cause");
    property p_rise_b;
        $rose(irq_out_b) |-> cause_age < 4'h8;
    endproperty
    a_rise_b: assert property (p_rise_b) else $error("Pin b rose without cause");
    property p_fall_a;
        $fell(irq_out_a) |-> spi_age < 4'h8;
    endproperty
    a_fall_a: assert property (p_fall_a) else $error("Pin a fell without clear");
    property p_fall_b;
        $fell(irq_out_b) |-> spi_age < 4'h8;
    endproperty
    a_fall_b: assert property (p_fall_b) else $error("Pin b fell without clear");
    property p_cfg;
        !$stable({parity_pin_in_use, frame_pin_in_use, shared_pin_function}) |-> spi_age < 4'h8;
    endproperty
    a_cfg: assert property (p_cfg) else $error("Pin config changed unwritten");
    property p_oe;
        spi_sdio_oe |-> spi_age < 4'h8;
    endproperty
    a_oe: assert property (p_oe) else $error("Data driven while deselected");
    property p_sdio;
        $changed(spi_sdio_out) && spi_sdio_oe && $past(spi_sdio_oe) |-> fall_age < 4'h8;
    endproperty
    a_sdio: assert property (p_sdio) else $error("Read bit moved off clock fall");

    c_irq_a: cover property ($rose(irq_out_a));
    c_irq_b: cover property ($rose(irq_out_b));
    c_read: cover property ($rose(spi_sdio_oe));
    c_frame: cover property (shared_pin_function == 2'h2);
endmodule // deiu_top_monitor

bind deiu_top deiu_top_monitor i_deiu_top_monitor (
    .clk, .rst_b, .spi_sclk, .spi_cs_b, .spi_sdio_out, .spi_sdio_oe, .ev_sync_lost, .ev_sync_locked,
    .ev_sync_done, .ev_pll_unlock, .ev_pll_lock, .ev_over_threshold, .ev_output_muted, .ev_parity_fail,
    .ev_sample_check_fail, .ev_dll_warning, .ev_dll_lock, .fifo_wr_ptr, .fifo_rd_ptr, .fifo_wr_adv,
    .fifo_rd_adv, .irq_out_a, .irq_out_b, .parity_pin_in_use, .frame_pin_in_use, .shared_pin_function
);

//--- tb_dac_event_interrupt_unit.sv
// Self-checking testbench of the event interrupt unit
`timescale 1ns/10ps
module tb_dac_event_interrupt_unit;
    import deiu_pkg::*;
    logic         clk = 1'b0;
    logic         rst_b = 1'b0;
    logic [6:0]   ev_a = 7'h00;
    logic [7:4]   ev_b = 4'h0;
    logic [2:0]   wr = 3'h3;
    logic [2:0]   rd = 3'h0;
    logic         wr_adv = 1'b0;
    logic         rd_adv = 1'b0;
    logic         sclk, cs_b, sdio, sdo, oe, irq_a, irq_b, par, frm, en, r;
    deiu_pin_fn_t fn;
    deiu_byte_t   q, w;
    deiu_addr_t   g;
    int           bad_count = 0;
    int           compares = 0;
    int           cyc = 0;
    int           seed = 75918;
    int           k, p;

    always #12.5 clk = ~clk;

    deiu_host_model i_deiu_host_model (.clk(clk), .sclk(sclk), .cs_b(cs_b), .sdio(sdio), .sdio_out(sdo));

    deiu_top i_deiu_top (
        .clk(clk), .rst_b(rst_b), .spi_sclk(sclk), .spi_cs_b(cs_b), .spi_sdio_in(sdio), .spi_sdio_out(sdo),
        .spi_sdio_oe(oe), .ev_sync_lost(ev_a[6]), .ev_sync_locked(ev_a[5]), .ev_sync_done(ev_a[4]),
        .ev_pll_unlock(ev_a[3]), .ev_pll_lock(ev_a[2]), .ev_over_threshold(ev_a[1]), .ev_output_muted(ev_a[0]),
        .ev_parity_fail(ev_b[7]), .ev_sample_check_fail(ev_b[6]), .ev_dll_warning(ev_b[5]),
        .ev_dll_lock(ev_b[4]), .fifo_wr_ptr(wr), .fifo_rd_ptr(rd), .fifo_wr_adv(wr_adv), .fifo_rd_adv(rd_adv),
        .irq_out_a(irq_a), .irq_out_b(irq_b), .parity_pin_in_use(par), .frame_pin_in_use(frm),
        .shared_pin_function(fn)
    );

    task automatic results();
        $display("Compares %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rw(input logic rdn, input deiu_addr_t a, input deiu_byte_t d);
        i_deiu_host_model.xfer(rdn, a, d, q);
    endtask

    function automatic deiu_byte_t msk(input deiu_addr_t a);
        case (a)
            7'h03, 7'h07: return 8'h7f;
            7'h04, 7'h08: return 8'hf7;
            7'h09: return 8'h33;
            default: return 8'h00;
        endcase
    endfunction

    function automatic int bpos(input int s);
        return s < 7 ? s : s - 7 + int'(s > 9);
    endfunction

    // Pointer events also reach the level alert
    function automatic deiu_byte_t xfl(input int s);
        xfl = 8'h01 << bpos(s);
        if (s == 8 || s == 9) xfl[0] = 1'b1;
    endfunction

    task automatic fire(input int s, input int b);
        @(posedge clk);
        if (s < 7) ev_a[b] <= 1'b1;
        else if (b > 3) ev_b[b] <= 1'b1;
        else if (b == 0) wr <= 3'h6;
        else begin
            wr <= (b == 1) ? 3'h1 : 3'h3;
            rd <= 3'h2;
            @(posedge clk);
            wr_adv <= (b == 1);
            rd_adv <= (b == 2);
        end
        @(posedge clk);
        ev_a <= 7'h00;
        ev_b <= 4'h0;
        wr_adv <= 1'b0;
        rd_adv <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            bad_count++;
            results();
        end
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 3; i < 11; i++) begin
            rw(1'b1, 7'(i), 8'h00);
            chk(q, 8'h00);
        end
        for (int i = 3; i < 11; i++) begin
            w = 8'($random(seed));
            rw(1'b0, 7'(i), w);
            rw(1'b1, 7'(i), 8'h00);
            chk(q, w & msk(7'(i)));
        end
        for (int f = 0; f < 4; f++) begin
            w = {2'b00, f == 1, f == 2, 2'b00, 2'(f)} | (8'($random(seed)) & 8'hcc);
            rw(1'b0, 7'h09, w);
            rw(1'b1, 7'h09, 8'h00);
            chk(q, w & 8'h33);
            chk({2'b00, par, frm, 2'b00, fn}, w & 8'h33);
        end
        for (int n = 0; n < 28; n++) begin
            k = n % 14;
            p = bpos(k);
            g = (k < 7) ? 7'h00 : 7'h01;
            en = (n < 14) ? 1'b1 : 1'($random(seed));
            r = 1'($random(seed));
            i_deiu_host_model.half = 5 + n % 2;
            rw(1'b0, 7'h03 + g, en ? 8'h01 << p : 8'h00);
            rw(1'b0, 7'h07 + g, {8{r}});
            fire(k, p);
            chk({6'h00, irq_a, irq_b}, {6'h00, en & !r, en & r});
            wr <= 3'h3;
            rd <= 3'h0;
            rw(1'b1, 7'h05 + g, 8'h00);
            chk(q, xfl(k)); // to
            rw(1'b0, 7'h05 + g, 8'hff);
            rw(1'b1, 7'h05 + g, 8'h00);
            chk(q, 8'h00);
            chk({6'h00, irq_a, irq_b}, 8'h00);
        end
        results();
    end
endmodule // tb_dac_event_interrupt_unit
